// *** common/etwb_defs.svh ***
// timing, width and bit-position constants for the two-wire front end
`ifndef ETWB_DEFS_SVH
`define ETWB_DEFS_SVH
`define ETWB_CLK_NS 50
`define ETWB_SPIKE_NS 50
`define ETWB_HOLD_NS 300
`define ETWB_FILT_CYC ((`ETWB_SPIKE_NS + `ETWB_CLK_NS - 1) / `ETWB_CLK_NS)
`define ETWB_HOLD_CYC ((`ETWB_HOLD_NS + `ETWB_CLK_NS - 1) / `ETWB_CLK_NS)
`define ETWB_QTR_CYC 25
`define ETWB_CNT_W 5
`define ETWB_BYTE_W 8
`define ETWB_FIFO_D 8
`define ETWB_LN_SCL 0
`define ETWB_LN_SDA 1
`define ETWB_RW_BIT 0
`define ETWB_LAST_BIT 4'h7
`define ETWB_ACK_SLOT 4'h8
`define ETWB_IDLE_BYTE 8'hFF
`define ETWB_CNT_ZERO 5'h00
`define ETWB_CNT_ONE 5'h01
`endif

// *** common/etwb_pkg.sv ***
// shared types of the two-wire front end
`include "etwb_defs.svh"
package etwb_pkg;
  typedef logic [`ETWB_BYTE_W-1:0] etwb_byte_t;
  typedef enum logic [2:0] {ETWB_S_IDLE, ETWB_S_RX, ETWB_S_RACK, ETWB_S_TX,
    ETWB_S_TACK} etwb_slv_state_t;
  typedef enum logic [1:0] {ETWB_M_IDLE, ETWB_M_START, ETWB_M_BIT,
    ETWB_M_STOP} etwb_mst_state_t;
  typedef enum logic [1:0] {ETWB_CMD_START, ETWB_CMD_STOP, ETWB_CMD_WRITE,
    ETWB_CMD_READ} etwb_cmd_t;
endpackage

// *** common/etwb_bus_if.sv ***
// open-drain two-wire bus joining master and slave ends
`timescale 1ns/100ps
interface etwb_bus_if;
  logic scl_out;
  logic scl_oe;
  logic m_sda_out;
  logic m_sda_oe;
  logic s_sda_out;
  logic s_sda_oe;
  logic scl;
  logic sda;
  // wired-and with pull-up: any enabled low driver wins
  assign scl = ~(scl_oe & ~scl_out);
  assign sda = ~((m_sda_oe & ~m_sda_out) | (s_sda_oe & ~s_sda_out));
  modport device (input scl, input sda, output s_sda_out, output s_sda_oe);
  modport master (input scl, input sda, output scl_out, output scl_oe,
    output m_sda_out, output m_sda_oe);
endinterface

// *** logic/etwb_slave.sv ***
// slave end of the two-wire bus with receive fifo
//
// Function
// - slave only pulls data low or releases
// - master changes data only while clock low
// - data change during clock high is condition
// - master owns clock, start and stop
// - master picks direction, slave follows it
// - master starts only on idle bus; etwb_master issues a start whenever commanded, without checking the bus
// - transmit data held 300 ns after fall
// - spikes up to 50 ns are ignored
// - clock edges time every shifted bit
// - start condition begins decoding
// - stop condition returns to idle
// - receiver pulls data low in ninth slot
// - no acknowledge during programming cycle
`timescale 1ns/100ps
`include "etwb_defs.svh"

module etwb_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // fill side
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  // drain side
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_idx;
  logic [AW-1:0] rd_idx;
  logic [AW:0] count;
  wire push = in_valid & in_ready;
  wire pop = out_valid & out_ready;
  wire [AW-1:0] last_idx = AW'(DEPTH - 1);

  // honest full and empty from the fill count
  assign in_ready = count != (AW + 1)'(DEPTH);
  assign out_valid = count != '0;
  assign out_data = mem[rd_idx];

  // storage written by index, never reset
  always_ff @(posedge ref_clk)
    if (clk_en && push)
      mem[wr_idx] <= in_data;

  // pointers wrap at the depth, not at a power of two
  always_ff @(posedge ref_clk)
    if (!rst_n)
    begin
      wr_idx <= '0;
      rd_idx <= '0;
      count <= '0;
    end
    else if (clk_en)
    begin
      if (push)
        wr_idx <= (wr_idx == last_idx) ? '0 : wr_idx + 1'b1;
      if (pop)
        rd_idx <= (rd_idx == last_idx) ? '0 : rd_idx + 1'b1;
      count <= count + (AW + 1)'(push) - (AW + 1)'(pop);
    end
endmodule // etwb_fifo

module etwb_slave (
  // clock, reset, enable
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // two-wire bus
  etwb_bus_if.device bus,
  // received bytes
  output etwb_pkg::etwb_byte_t rx_data,
  output logic rx_valid,
  input wire logic rx_ready,
  // bytes to transmit
  input wire etwb_pkg::etwb_byte_t tx_data,
  input wire logic tx_valid,
  output logic tx_ready,
  // status
  input wire logic busy,
  output logic start_seen,
  output logic stop_seen,
  output logic read_mode
);
  import etwb_pkg::*;

  logic [1:0] sync1;
  logic [1:0] sync2;
  logic [1:0] flt;
  logic [1:0] flt_p;
  logic [`ETWB_CNT_W-1:0] fcnt [2];
  wire [1:0] pin_in = {bus.sda, bus.scl};

  // two flops then a stability counter per line
  generate
    for (genvar i = 0; i < 2; i++)
    begin : g_line
      always_ff @(posedge ref_clk)
        if (!rst_n)
        begin
          sync1[i] <= 1'b1;
          sync2[i] <= 1'b1;
          flt[i] <= 1'b1;
          fcnt[i] <= `ETWB_CNT_ZERO;
        end
        else if (clk_en)
        begin
          sync1[i] <= pin_in[i];
          sync2[i] <= sync1[i];
          if (sync2[i] == flt[i])
            fcnt[i] <= `ETWB_CNT_ZERO;
          else if (fcnt[i] == `ETWB_CNT_W'(`ETWB_FILT_CYC))
          begin
            flt[i] <= sync2[i];
            fcnt[i] <= `ETWB_CNT_ZERO;
          end
          else
            fcnt[i] <= fcnt[i] + `ETWB_CNT_ONE;
        end
    end
  endgenerate

  // edges and bus conditions from filtered lines
  wire scl_f = flt[`ETWB_LN_SCL];
  wire sda_f = flt[`ETWB_LN_SDA];
  wire scl_hold = scl_f & flt_p[`ETWB_LN_SCL];
  wire scl_rise = scl_f & ~flt_p[`ETWB_LN_SCL];
  wire scl_fall = ~scl_f & flt_p[`ETWB_LN_SCL];
  wire start_c = scl_hold & flt_p[`ETWB_LN_SDA] & ~sda_f;
  wire stop_c = scl_hold & ~flt_p[`ETWB_LN_SDA] & sda_f;

  etwb_slv_state_t state;
  logic [3:0] bit_cnt;
  etwb_byte_t sh;
  logic first;
  logic acked;
  logic target_low;
  logic drive_low;
  logic [`ETWB_CNT_W-1:0] hold_cnt;
  logic fifo_ready;

  // byte boundary decisions
  wire rx_done = scl_fall & (state == ETWB_S_RX) & (bit_cnt == `ETWB_ACK_SLOT);
  wire give_ack = ~busy & (first | fifo_ready);
  wire push = rx_done & ~first & ~busy & fifo_ready;
  wire rack_end = scl_fall & (state == ETWB_S_RACK);
  wire tack_end = scl_fall & (state == ETWB_S_TACK);
  wire load_tx = (rack_end & acked & read_mode) | (tack_end & acked);
  assign tx_ready = load_tx & tx_valid;
  wire [`ETWB_BYTE_W-1:0] tx_byte = tx_valid ? tx_data : `ETWB_IDLE_BYTE;

  // data pin only ever pulls low
  assign bus.s_sda_out = 1'b0;
  assign bus.s_sda_oe = drive_low;

  // full fifo withholds the ack so the master backs off
  etwb_fifo #(.WIDTH(`ETWB_BYTE_W), .DEPTH(`ETWB_FIFO_D)) i_etwb_fifo (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .in_valid(push),
    .in_data(sh),
    .in_ready(fifo_ready),
    .out_valid(rx_valid),
    .out_data(rx_data),
    .out_ready(rx_ready)
  );

  // protocol sequencer; conditions override any byte in flight
  always_ff @(posedge ref_clk)
    if (!rst_n)
    begin
      state <= ETWB_S_IDLE;
      bit_cnt <= 4'h0;
      sh <= 8'h00;
      first <= 1'b0;
      acked <= 1'b0;
      read_mode <= 1'b0;
      target_low <= 1'b0;
      flt_p <= 2'h3;
    end
    else if (clk_en)
    begin
      flt_p <= flt;
      if (start_c)
      begin
        state <= ETWB_S_RX;
        bit_cnt <= 4'h0;
        first <= 1'b1;
        read_mode <= 1'b0;
        target_low <= 1'b0;
      end
      else if (stop_c)
      begin
        state <= ETWB_S_IDLE;
        target_low <= 1'b0;
      end
      else
        case (state)
          ETWB_S_RX:
            if (scl_rise && bit_cnt != `ETWB_ACK_SLOT)
            begin
              sh <= {sh[6:0], sda_f};
              bit_cnt <= bit_cnt + 4'h1;
            end
            else if (rx_done)
            begin
              state <= ETWB_S_RACK;
              acked <= give_ack;
              target_low <= give_ack;
              if (first)
                read_mode <= sh[`ETWB_RW_BIT];
            end
          ETWB_S_RACK:
            if (scl_fall)
            begin
              first <= 1'b0;
              bit_cnt <= 4'h0;
              target_low <= 1'b0;
              if (!acked)
                state <= ETWB_S_IDLE;
              else if (read_mode)
              begin
                state <= ETWB_S_TX;
                sh <= tx_byte;
                target_low <= ~tx_byte[7];
              end
              else
                state <= ETWB_S_RX;
            end
          ETWB_S_TX:
            if (scl_fall && bit_cnt == `ETWB_LAST_BIT)
            begin
              state <= ETWB_S_TACK;
              target_low <= 1'b0;
            end
            else if (scl_fall)
            begin
              sh <= {sh[6:0], 1'b0};
              target_low <= ~sh[6];
              bit_cnt <= bit_cnt + 4'h1;
            end
          ETWB_S_TACK:
            if (scl_rise)
              acked <= ~sda_f;
            else if (tack_end && acked)
            begin
              state <= ETWB_S_TX;
              bit_cnt <= 4'h0;
              sh <= tx_byte;
              target_low <= ~tx_byte[7];
            end
            else if (tack_end)
              state <= ETWB_S_IDLE; // leave line high for the stop
          default:
            state <= ETWB_S_IDLE;
        endcase
    end

  // pin changes only after the post-fall hold window
  always_ff @(posedge ref_clk)
    if (!rst_n)
    begin
      drive_low <= 1'b0;
      hold_cnt <= `ETWB_CNT_ZERO;
    end
    else if (clk_en)
    begin
      if (start_c || stop_c)
      begin
        drive_low <= 1'b0;
        hold_cnt <= `ETWB_CNT_ZERO;
      end
      else if (scl_fall)
        hold_cnt <= `ETWB_CNT_W'(`ETWB_HOLD_CYC);
      else if (hold_cnt != `ETWB_CNT_ZERO)
      begin
        hold_cnt <= hold_cnt - `ETWB_CNT_ONE;
        if (hold_cnt == `ETWB_CNT_ONE)
          drive_low <= target_low;
      end
    end

  // condition pulses for the neighbouring command logic
  always_ff @(posedge ref_clk)
    if (!rst_n)
    begin
      start_seen <= 1'b0;
      stop_seen <= 1'b0;
    end
    else if (clk_en)
    begin
      start_seen <= start_c;
      stop_seen <= stop_c;
    end
endmodule // etwb_slave

// *** logic/etwb_master.sv ***
// master end: makes the bus clock and runs start, byte and stop commands
`timescale 1ns/100ps
`include "etwb_defs.svh"

module etwb_master (
  // clock, reset, enable
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // two-wire bus
  etwb_bus_if.master bus,
  // command
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire etwb_pkg::etwb_cmd_t cmd_code,
  input wire etwb_pkg::etwb_byte_t cmd_data,
  input wire logic cmd_nack,
  // response
  output logic rsp_valid,
  output etwb_pkg::etwb_byte_t rsp_data,
  output logic rsp_ack,
  output logic bus_busy
);
  import etwb_pkg::*;

  etwb_mst_state_t state;
  logic [`ETWB_CNT_W-1:0] tick;
  logic [1:0] qtr;
  logic [3:0] bit_cnt;
  logic [8:0] sh;
  logic [8:0] rx;
  logic sda_s1;
  logic sda_s2;
  logic scl_hi;
  logic sda_low;
  logic next_scl_hi;
  logic next_sda_low;

  // quarter boundaries and command acceptance
  wire qtr_end = tick == `ETWB_CNT_ZERO;
  wire take = cmd_valid & cmd_ready;
  wire last_q = qtr_end & (qtr == 2'h3);
  wire byte_end = last_q & (state == ETWB_M_BIT) & (bit_cnt == `ETWB_ACK_SLOT);
  assign cmd_ready = state == ETWB_M_IDLE;

  // open-drain pins; the clock is only ours to make
  assign bus.scl_out = 1'b0;
  assign bus.scl_oe = ~scl_hi;
  assign bus.m_sda_out = 1'b0;
  assign bus.m_sda_oe = sda_low;

  // line levels per quarter; data moves while clock low except in start and stop
  always_comb
  begin
    next_scl_hi = scl_hi;
    next_sda_low = 1'b0;
    case (state)
      ETWB_M_START:
      begin
        next_scl_hi = (qtr == 2'h1) | (qtr == 2'h2);
        next_sda_low = qtr[1];
      end
      ETWB_M_BIT:
      begin
        next_scl_hi = (qtr == 2'h1) | (qtr == 2'h2);
        next_sda_low = ~sh[8];
      end
      ETWB_M_STOP:
      begin
        next_scl_hi = qtr != 2'h0;
        next_sda_low = ~qtr[1];
      end
      default:
        next_sda_low = 1'b0;
    endcase
  end

  // sequencer; ends with clock parked low except after stop
  always_ff @(posedge ref_clk)
    if (!rst_n)
    begin
      state <= ETWB_M_IDLE;
      tick <= `ETWB_CNT_ZERO;
      qtr <= 2'h0;
      bit_cnt <= 4'h0;
      sh <= 9'h1FF;
      scl_hi <= 1'b1;
      sda_low <= 1'b0;
      bus_busy <= 1'b0;
    end
    else if (clk_en)
    begin
      scl_hi <= next_scl_hi;
      sda_low <= next_sda_low;
      if (take)
      begin
        tick <= `ETWB_CNT_W'(`ETWB_QTR_CYC - 1);
        qtr <= 2'h0;
        bit_cnt <= 4'h0;
        case (cmd_code)
          ETWB_CMD_START: state <= ETWB_M_START;
          ETWB_CMD_STOP: state <= ETWB_M_STOP;
          ETWB_CMD_WRITE: state <= ETWB_M_BIT;
          default: state <= ETWB_M_BIT;
        endcase
        sh <= (cmd_code == ETWB_CMD_WRITE) ? {cmd_data, 1'b1}
          : {`ETWB_IDLE_BYTE, cmd_nack};
      end
      else if (state != ETWB_M_IDLE && qtr_end)
      begin
        tick <= `ETWB_CNT_W'(`ETWB_QTR_CYC - 1);
        qtr <= qtr + 2'h1;
        if (last_q && state == ETWB_M_BIT && bit_cnt != `ETWB_ACK_SLOT)
        begin
          sh <= {sh[7:0], 1'b1};
          bit_cnt <= bit_cnt + 4'h1;
        end
        else if (last_q)
        begin
          if (state == ETWB_M_START)
            bus_busy <= 1'b1;
          if (state == ETWB_M_STOP)
            bus_busy <= 1'b0;
          state <= ETWB_M_IDLE;
        end
      end
      else if (state != ETWB_M_IDLE)
        tick <= tick - `ETWB_CNT_ONE;
    end

  // sample data at the end of the second clock-high quarter
  always_ff @(posedge ref_clk)
    if (!rst_n)
    begin
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
      rx <= 9'h000;
      rsp_valid <= 1'b0;
      rsp_data <= 8'h00;
      rsp_ack <= 1'b0;
    end
    else if (clk_en)
    begin
      sda_s1 <= bus.sda;
      sda_s2 <= sda_s1;
      rsp_valid <= byte_end;
      if (qtr_end && qtr == 2'h2 && state == ETWB_M_BIT)
        rx <= {rx[7:0], sda_s2};
      if (byte_end)
      begin
        // oldest sample is the first data bit, newest the ack slot
        rsp_data <= rx[8:1];
        rsp_ack <= ~sh[8] | ~rx[0];
      end
    end
endmodule // etwb_master

// *** testbench/etwb_bus_asserts.sv ***
// bus-level assertions on the two-wire link between both ends
`timescale 1ns/100ps
module etwb_bus_asserts (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // line drivers
  input wire logic scl_out,
  input wire logic scl_oe,
  input wire logic m_sda_out,
  input wire logic m_sda_oe,
  input wire logic s_sda_out,
  input wire logic s_sda_oe,
  // wired levels
  input wire logic scl,
  input wire logic sda
);
  logic [7:0] lo_cnt;
  logic [7:0] hi_cnt;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  // phase lengths; saturate so a long idle span cannot wrap
  always_ff @(posedge ref_clk)
  begin
    lo_cnt <= (scl || !rst_n) ? 8'h00 : lo_cnt + {7'h00, lo_cnt != 8'hFF};
    hi_cnt <= (!scl || !rst_n) ? 8'h00 : hi_cnt + {7'h00, hi_cnt != 8'hFF};
  end
  property p_open_drain;
    !(s_sda_oe && s_sda_out) && !(m_sda_oe && m_sda_out)
      && !(scl_oe && scl_out);
  endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("line driven high");
  property p_reset_idle;
    $rose(rst_n) |-> !s_sda_oe && !m_sda_oe && !scl_oe;
  endproperty
  a_reset_idle: assert property (p_reset_idle)
    else $error("lines not released after reset");
  property p_tx_hold;
    $fell(scl) |-> $stable(s_sda_oe) [*7];
  endproperty
  a_tx_hold: assert property (p_tx_hold)
    else $error("slave drive changed too soon after clock fall");
  property p_drive_late;
    $changed(s_sda_oe) |-> !scl && lo_cnt inside {[8:16]};
  endproperty
  a_drive_late: assert property (p_drive_late)
    else $error("slave drive not timed from clock fall");
  property p_ack_steady;
    scl && $past(scl) |-> $stable(s_sda_oe);
  endproperty
  a_ack_steady: assert property (p_ack_steady)
    else $error("slave drive moved while clock high");
  property p_clock_low;
    $rose(scl) |-> lo_cnt inside {[24:26], [49:51]};
  endproperty
  a_clock_low: assert property (p_clock_low)
    else $error("clock low phase off");
  property p_cond_mid;
    scl && $changed(m_sda_oe) |-> hi_cnt inside {[23:27]};
  endproperty
  a_cond_mid: assert property (p_cond_mid)
    else $error("master data moved outside a condition slot");
  property p_stop_quiet;
    scl && $past(scl) && $rose(sda) |-> !s_sda_oe [*8];
  endproperty
  a_stop_quiet: assert property (p_stop_quiet)
    else $error("slave drives after stop");
endmodule // etwb_bus_asserts

// *** testbench/etwb_test.sv ***
// bench: master and slave on one bus, a second slave on a driven link
`timescale 1ns/100ps
module etwb_test;
  import etwb_pkg::*;
  // control byte value is arbitrary apart from its low bit, which must be 0 for a write
  localparam etwb_byte_t ctrl = 8'h36;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic run = 1'b1;
  logic cmd_valid = 1'b0;
  logic cmd_nack = 1'b0;
  etwb_cmd_t cmd_code = ETWB_CMD_START;
  etwb_byte_t cmd_data = 8'h00;
  etwb_byte_t tx_data = 8'hC3;
  logic tx_valid = 1'b0;
  logic busy = 1'b0;
  logic lvl = 1'b1;
  logic [1:0] rdy = 2'h0;
  logic vld [2];
  etwb_byte_t rxd [2];
  etwb_byte_t rsp_data;
  logic cmd_ready, rsp_valid, rsp_ack, bus_busy;
  logic start_seen, stop_seen, read_mode;
  int failures = 0;
  int n_checks = 0;
  int n_start = 0;
  int n_stop = 0;
  etwb_bus_if bus ();
  etwb_bus_if bus_b ();
  etwb_master i_etwb_master (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(run),
    .bus(bus), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_code(cmd_code), .cmd_data(cmd_data), .cmd_nack(cmd_nack),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_ack(rsp_ack),
    .bus_busy(bus_busy));
  etwb_slave i_etwb_slave (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(run),
    .bus(bus), .rx_data(rxd[0]), .rx_valid(vld[0]), .rx_ready(rdy[0]),
    .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(), .busy(busy),
    .start_seen(start_seen), .stop_seen(stop_seen), .read_mode(read_mode));
  // second slave faces the bench's own glitchy driver
  etwb_slave i_etwb_slave_b (.ref_clk(ref_clk), .rst_n(rst_n),
    .clk_en(run), .bus(bus_b), .rx_data(rxd[1]), .rx_valid(vld[1]),
    .rx_ready(rdy[1]), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_ready(), .busy(busy), .start_seen(), .stop_seen(), .read_mode());
  etwb_bus_asserts i_etwb_bus_asserts (.ref_clk(ref_clk), .rst_n(rst_n),
    .scl_out(bus.scl_out), .scl_oe(bus.scl_oe), .m_sda_out(bus.m_sda_out),
    .m_sda_oe(bus.m_sda_oe), .s_sda_out(bus.s_sda_out),
    .s_sda_oe(bus.s_sda_oe), .scl(bus.scl), .sda(bus.sda));
  always #25 ref_clk = ~ref_clk;
  // condition pulses from the slave end
  always @(posedge ref_clk)
  begin
    n_start <= n_start + (start_seen === 1'b1);
    n_stop <= n_stop + (stop_seen === 1'b1);
  end
  task automatic check(input string what, input logic [7:0] seen,
    input logic [7:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // request held until the edge that sees cmd_ready, then dropped
  task automatic cmd(input etwb_cmd_t c, input etwb_byte_t d,
    input logic nk);
    int n;
    n = 0;
    cmd_code = c;
    cmd_data = d;
    cmd_nack = nk;
    cmd_valid = 1'b1;
    while (cmd_ready !== 1'b1 && n < 2000)
    begin
      @(negedge ref_clk);
      n++;
    end
    if (n == 2000)
      failures++;
    @(negedge ref_clk);
    cmd_valid = 1'b0;
    n = 0;
    // byte commands wait for the response, conditions for idle again,
    // so the next call never raises valid in the step that lowered it
    while (n < 2000 && ((c inside {ETWB_CMD_WRITE, ETWB_CMD_READ})
      ? (rsp_valid !== 1'b1) : (cmd_ready !== 1'b1)))
    begin
      @(negedge ref_clk);
      n++;
    end
    if (n == 2000)
      failures++;
  endtask
  task automatic wr(input etwb_byte_t d, input logic ack);
    cmd(ETWB_CMD_WRITE, d, 1'b0);
    check("write ack", rsp_ack, ack);
  endtask
  task automatic rd(input logic nk, input etwb_byte_t d);
    cmd(ETWB_CMD_READ, 8'h00, nk);
    check("read data", rsp_data, d);
    check("read ack", rsp_ack, !nk);
  endtask
  task automatic pop(input int b, input etwb_byte_t d);
    check("fifo valid", vld[b], 1'b1);
    check("fifo data", rxd[b], d);
    rdy[b] = 1'b1;
    @(negedge ref_clk);
    rdy[b] = 1'b0;
    // let an edge pass so a following pop does not re-raise in this step
    @(negedge ref_clk);
  endtask
  // drive the second link: clock level, data level, cycles to hold
  task automatic b_set(input logic c, input logic d, input int n);
    bus_b.scl_oe = ~c;
    bus_b.m_sda_oe = ~d;
    repeat (n) @(negedge ref_clk);
  endtask
  // k 1: one-cycle clock spike while low; k 2: data spike while high
  task automatic b_bit(input logic v, input int k);
    b_set(1'b0, lvl, 4);
    lvl = v;
    b_set(1'b0, v, 6);
    b_set(k == 1, v, 1);
    b_set(1'b0, v, 9);
    b_set(1'b1, v, 8);
    b_set(1'b1, (k == 2) ? ~v : v, 1);
    b_set(1'b1, v, 11);
  endtask
  task automatic b_byte(input etwb_byte_t d, input logic ack, input int p,
    input int k);
    for (int i = 0; i < 8; i++)
      b_bit(d[7-i], (i == p) ? k : 0);
    b_set(1'b0, lvl, 4);
    lvl = 1'b1;
    b_set(1'b0, 1'b1, 16);
    b_set(1'b1, 1'b1, 10);
    check("link ack", bus_b.sda, !ack);
    b_set(1'b1, 1'b1, 10);
  endtask
  task automatic b_cond(input logic first, input logic last);
    b_set(1'b0, lvl, 4);
    b_set(1'b0, first, 16);
    b_set(1'b1, first, 20);
    b_set(1'b1, last, 20);
    lvl = last;
  endtask
  initial
  begin
    bus_b.scl_out = 1'b0;
    bus_b.m_sda_out = 1'b0;
    bus_b.scl_oe = 1'b0;
    bus_b.m_sda_oe = 1'b0;
    repeat (10) @(negedge ref_clk);
    rst_n = 1'b1;
    // write: control byte then two data bytes
    cmd(ETWB_CMD_START, 8'h00, 1'b0);
    wr(ctrl, 1'b1);
    check("bus busy", bus_busy, 1'b1);
    check("read mode", read_mode, 1'b0);
    wr(8'h5A, 1'b1);
    wr(8'h81, 1'b1);
    cmd(ETWB_CMD_STOP, 8'h00, 1'b0);
    repeat (110) @(negedge ref_clk);
    check("bus busy", bus_busy, 1'b0);
    check("starts", n_start[7:0], 8'h01);
    check("stops", n_stop[7:0], 8'h01);
    pop(0, 8'h5A);
    pop(0, 8'h81);
    check("fifo empty", vld[0], 1'b0);
    $display("test write done");
    // read with ack then no-ack, repeated start, empty source
    tx_valid = 1'b1;
    cmd(ETWB_CMD_START, 8'h00, 1'b0);
    wr(ctrl | 8'h01, 1'b1);
    check("read mode", read_mode, 1'b1);
    rd(1'b0, 8'hC3);
    rd(1'b1, 8'hC3);
    tx_valid = 1'b0;
    cmd(ETWB_CMD_START, 8'h00, 1'b0);
    wr(ctrl | 8'h01, 1'b1);
    rd(1'b1, 8'hFF);
    cmd(ETWB_CMD_STOP, 8'h00, 1'b0);
    $display("test read done");
    // programming cycle: control byte gets no acknowledge
    busy = 1'b1;
    cmd(ETWB_CMD_START, 8'h00, 1'b0);
    wr(ctrl, 1'b0);
    cmd(ETWB_CMD_STOP, 8'h00, 1'b0);
    busy = 1'b0;
    check("fifo empty", vld[0], 1'b0);
    $display("test busy done");
    // fill the fifo while the reader stalls, ninth byte refused
    cmd(ETWB_CMD_START, 8'h00, 1'b0);
    wr(ctrl, 1'b1);
    for (int i = 0; i < 8; i++)
      wr(8'h10 + i[7:0], 1'b1);
    wr(8'hEE, 1'b0);
    cmd(ETWB_CMD_STOP, 8'h00, 1'b0);
    for (int i = 0; i < 8; i++)
      pop(0, 8'h10 + i[7:0]);
    check("fifo empty", vld[0], 1'b0);
    $display("test fifo done");
    // driven link: spikes, then a stop in mid-byte
    b_cond(1'b1, 1'b0);
    b_byte(ctrl, 1'b1, 3, 1);
    b_byte(8'h96, 1'b1, 3, 2);
    b_cond(1'b0, 1'b1);
    b_cond(1'b1, 1'b0);
    b_byte(ctrl, 1'b1, 8, 0);
    for (int i = 0; i < 4; i++)
      b_bit(1'b1, 0);
    b_cond(1'b0, 1'b1);
    b_cond(1'b1, 1'b0);
    b_byte(ctrl, 1'b1, 8, 0);
    b_byte(8'h3C, 1'b1, 8, 0);
    b_cond(1'b0, 1'b1);
    pop(1, 8'h96);
    pop(1, 8'h3C);
    check("link fifo empty", vld[1], 1'b0);
    $display("test link done");
    complete_run();
  end
  // watchdog well beyond the expected run length
  initial
  begin
    repeat (60000) @(posedge ref_clk);
    failures++;
    complete_run();
  end
endmodule // etwb_test
